// [hw/buck_pair_setpoint.sv]
// set-point and phasing configuration for a pair of buck channels
// assumes synchronous inputs, one clock, otp values stable during operation
//
// Overview of operation
// - two-bit otp code: 00/01 combined, 10 reserved, 11 independent
// - combined mode regulates from first channel; software sets both alike
// - independent mode: each channel uses only its own registers
// - normal range bit is read-only, taken from default or otp
// - range 0: 0.40 V to 1.975 V in 25 mV steps
// - range 1: 0.800 V to 3.300 V in 50 mV steps
// - three writable six-bit set-points per channel, chosen by state
// - at start-up range bit copied into standby and sleep codes
`timescale 1ns/1ps
`default_nettype none
`include "buck_pair_consts.svh"
module buck_pair_setpoint
  import buck_pair_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [`PHASE_W-1:0]  pair_phasing_code,
  input  wire logic                 otp_range_a,
  input  wire logic                 otp_range_b,
  input  wire logic                 init_load,
  input  wire logic [1:0]           op_state,
  input  wire logic [1:0]           wr_sel_a,
  input  wire logic                 wr_en_a,
  input  wire logic [`STEP_W-1:0]   wr_data_a,
  input  wire logic [1:0]           wr_sel_b,
  input  wire logic                 wr_en_b,
  input  wire logic [`STEP_W-1:0]   wr_data_b,
  output logic [`CODE_W-1:0]        normal_setpoint_code_a,
  output logic [`CODE_W-1:0]        standby_setpoint_code_a,
  output logic [`CODE_W-1:0]        sleep_setpoint_code_a,
  output logic [`CODE_W-1:0]        normal_setpoint_code_b,
  output logic [`CODE_W-1:0]        standby_setpoint_code_b,
  output logic [`CODE_W-1:0]        sleep_setpoint_code_b,
  output logic [`MV_W-1:0]          target_mv_a,
  output logic [`MV_W-1:0]          target_mv_b,
  output logic                      reserved_code_a,
  output logic                      reserved_code_b,
  output logic                      combined_mode,
  output logic                      phasing_reserved,
  output logic                      second_channel_enable
);
  // ************************************************************
  // phasing decode
  // ************************************************************
  function automatic phasing_t decode_phasing(input logic [`PHASE_W-1:0] c);
    case (c)
      `PHASE_SINGLE0: decode_phasing = phase_combined;
      `PHASE_SINGLE1: decode_phasing = phase_combined;
      `PHASE_INDEP:   decode_phasing = phase_independent;
      default:        decode_phasing = phase_reserved;
    endcase
  endfunction

  wire phasing_t phasing_now;
  assign phasing_now = decode_phasing(pair_phasing_code);
  wire logic is_combined;
  assign is_combined = (phasing_now == phase_combined);

  // ************************************************************
  // field decode helpers
  // ************************************************************
  // write strobe lands on one field, select 3 is refused
  function automatic logic write_hit(
    input logic       en,
    input logic [1:0] s,
    input logic [1:0] idx
  );
    write_hit = en && (s == idx) && (s != 2'h3);
  endfunction

  // state picks the field, unused state reads as normal
  function automatic logic [`STEP_W-1:0] pick_step(
    input logic [1:0]         st,
    input logic [`STEP_W-1:0] n,
    input logic [`STEP_W-1:0] sb,
    input logic [`STEP_W-1:0] sl
  );
    case (st)
      2'(st_standby): pick_step = sb;
      2'(st_sleep):   pick_step = sl;
      default:        pick_step = n;
    endcase
  endfunction

  // ************************************************************
  // set-point storage per channel
  // ************************************************************
  logic [`STEP_W-1:0] step_r [2][3];
  logic               range_r [2];
  wire logic [1:0]        sel [2];
  wire logic              wen [2];
  wire logic [`STEP_W-1:0] wdat [2];
  wire logic              otp_rng [2];
  assign sel[0] = wr_sel_a;
  assign sel[1] = wr_sel_b;
  assign wen[0] = wr_en_a;
  assign wen[1] = wr_en_b;
  assign wdat[0] = wr_data_a;
  assign wdat[1] = wr_data_b;
  assign otp_rng[0] = otp_range_a;
  assign otp_rng[1] = otp_range_b;

  wire logic [`CODE_W-1:0] code_sel [2];
  wire logic [`CODE_W-1:0] code_use [2];
  wire logic [`MV_W-1:0]   mv [2];
  wire logic               rsv [2];

  genvar ch;
  genvar k;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_ch
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          range_r[ch] <= `RANGE_RESET;
        end else if (init_load) begin
          range_r[ch] <= otp_rng[ch];
        end
      end
      for (k = 0; k < 3; k++) begin : g_st
        always_ff @(posedge core_clk or posedge rst) begin
          if (rst) begin
            step_r[ch][k] <= `STEP_RESET;
          end else if (write_hit(wen[ch], sel[ch], 2'(k))) begin
            step_r[ch][k] <= wdat[ch];
          end
        end
      end
      assign code_sel[ch] = {range_r[ch],
                             pick_step(op_state, step_r[ch][0], step_r[ch][1], step_r[ch][2])};
      setpoint_decoder u_dec (
        .code          (code_use[ch]),
        .target_mv     (mv[ch]),
        .reserved_code (rsv[ch])
      );
    end
  endgenerate

  assign code_use[0] = code_sel[0];
  assign code_use[1] = is_combined ? code_sel[0] : code_sel[1];

  // ************************************************************
  // next values of the output flops
  // ************************************************************
  wire logic [`CODE_W-1:0] normal_setpoint_code_a_nxt;
  wire logic [`CODE_W-1:0] standby_setpoint_code_a_nxt;
  wire logic [`CODE_W-1:0] sleep_setpoint_code_a_nxt;
  wire logic [`CODE_W-1:0] normal_setpoint_code_b_nxt;
  wire logic [`CODE_W-1:0] standby_setpoint_code_b_nxt;
  wire logic [`CODE_W-1:0] sleep_setpoint_code_b_nxt;
  wire logic [`MV_W-1:0]   target_mv_a_nxt;
  wire logic [`MV_W-1:0]   target_mv_b_nxt;
  wire logic               reserved_code_a_nxt;
  wire logic               reserved_code_b_nxt;
  wire logic               combined_mode_nxt;
  wire logic               phasing_reserved_nxt;
  wire logic               second_channel_enable_nxt;

  // codes carry the shared range bit on top
  assign normal_setpoint_code_a_nxt  = {range_r[0], step_r[0][0]};
  assign standby_setpoint_code_a_nxt = {range_r[0], step_r[0][1]};
  assign sleep_setpoint_code_a_nxt   = {range_r[0], step_r[0][2]};
  assign normal_setpoint_code_b_nxt  = {range_r[1], step_r[1][0]};
  assign standby_setpoint_code_b_nxt = {range_r[1], step_r[1][1]};
  assign sleep_setpoint_code_b_nxt   = {range_r[1], step_r[1][2]};
  // targets follow the state-selected code
  assign target_mv_a_nxt             = mv[0];
  assign target_mv_b_nxt             = mv[1];
  assign reserved_code_a_nxt         = rsv[0];
  assign reserved_code_b_nxt         = rsv[1];
  // phasing flags, one-hot over the three decodes
  assign combined_mode_nxt           = is_combined;
  assign phasing_reserved_nxt        = (phasing_now == phase_reserved);
  assign second_channel_enable_nxt   = (phasing_now == phase_independent);

  // ************************************************************
  // registered outputs
  // ************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      normal_setpoint_code_a  <= '0;
      standby_setpoint_code_a <= '0;
      sleep_setpoint_code_a   <= '0;
      normal_setpoint_code_b  <= '0;
      standby_setpoint_code_b <= '0;
      sleep_setpoint_code_b   <= '0;
      target_mv_a             <= '0;
      target_mv_b             <= '0;
      reserved_code_a         <= 1'b0;
      reserved_code_b         <= 1'b0;
      combined_mode           <= 1'b0;
      phasing_reserved        <= 1'b0;
      second_channel_enable   <= 1'b0;
    end else begin
      normal_setpoint_code_a  <= normal_setpoint_code_a_nxt;
      standby_setpoint_code_a <= standby_setpoint_code_a_nxt;
      sleep_setpoint_code_a   <= sleep_setpoint_code_a_nxt;
      normal_setpoint_code_b  <= normal_setpoint_code_b_nxt;
      standby_setpoint_code_b <= standby_setpoint_code_b_nxt;
      sleep_setpoint_code_b   <= sleep_setpoint_code_b_nxt;
      target_mv_a             <= target_mv_a_nxt;
      target_mv_b             <= target_mv_b_nxt;
      reserved_code_a         <= reserved_code_a_nxt;
      reserved_code_b         <= reserved_code_b_nxt;
      combined_mode           <= combined_mode_nxt;
      phasing_reserved        <= phasing_reserved_nxt;
      second_channel_enable   <= second_channel_enable_nxt;
    end
  end
endmodule // buck_pair_setpoint
`default_nettype wire

// [common/buck_pair_consts.svh]
// constants for the buck pair set-point block
// assumes nothing beyond a plain include
`ifndef BUCK_PAIR_CONSTS_SVH
`define BUCK_PAIR_CONSTS_SVH
`define CODE_W          7
`define STEP_W          6
`define RANGE_BIT       6
`define PHASE_W         2
`define PHASE_SINGLE0   2'h0
`define PHASE_SINGLE1   2'h1
`define PHASE_RESERVED  2'h2
`define PHASE_INDEP     2'h3
`define MV_W            12
`define LOW_BASE_MV     12'h190
`define LOW_STEP_MV     12'h019
`define HIGH_BASE_MV    12'h320
`define HIGH_STEP_MV    12'h032
`define HIGH_MAX_MV     12'h0CE4
`define STEP_RESET      6'h00
`define RANGE_RESET     1'b0
`endif

// [common/buck_pair_pkg.sv]
// types for the buck pair set-point block
// assumes the constants header is on the include path
`default_nettype none
package buck_pair_pkg;
  typedef enum logic [1:0] {
    st_normal,
    st_standby,
    st_sleep,
    st_unused
  } op_state_t;
  typedef enum logic [1:0] {
    phase_combined,
    phase_independent,
    phase_reserved
  } phasing_t;
endpackage
`default_nettype wire

// [hw/setpoint_decoder.sv]
// set-point code to millivolt decoder
// assumes a 7-bit code with the range bit on top
`timescale 1ns/1ps
`default_nettype none
`include "buck_pair_consts.svh"
module setpoint_decoder (
  input  wire logic [`CODE_W-1:0] code,
  output logic      [`MV_W-1:0]   target_mv,
  output logic                    reserved_code
);
  wire logic [`MV_W-1:0] step_ext;
  wire logic [`MV_W-1:0] low_mv;
  wire logic [`MV_W-1:0] high_mv;
  assign step_ext = {{(`MV_W-`STEP_W){1'b0}}, code[`STEP_W-1:0]};
  assign low_mv  = `MV_W'(`LOW_BASE_MV + step_ext * `LOW_STEP_MV);
  assign high_mv = `MV_W'(`HIGH_BASE_MV + step_ext * `HIGH_STEP_MV);
  assign target_mv = code[`RANGE_BIT] ? high_mv : low_mv;
  assign reserved_code = code[`RANGE_BIT] && (high_mv > `HIGH_MAX_MV);
endmodule // setpoint_decoder
`default_nettype wire

// [tb/buck_pair_asserts.sv]
// checker for the buck pair set-point block
// bound to the design top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module buck_pair_asserts (
  input wire logic        core_clk, rst, init_load, wr_en_a, reserved_code_a,
  input wire logic        combined_mode, phasing_reserved, second_channel_enable,
  input wire logic [1:0]  pair_phasing_code, op_state, wr_sel_a,
  input wire logic [5:0]  wr_data_a,
  input wire logic [6:0]  normal_setpoint_code_a, standby_setpoint_code_a,
  input wire logic [6:0]  sleep_setpoint_code_a, normal_setpoint_code_b,
  input wire logic [11:0] target_mv_a, target_mv_b
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  function automatic logic [11:0] mv(input logic [6:0] c);
    return c[6] ? 12'h320 + 12'h32 * c[5:0] : 12'h190 + 12'h19 * c[5:0];
  endfunction
  sequence wr_norm_s; wr_en_a && wr_sel_a == 2'h0; endsequence
  phase_decode_a:
    assert property (!$past(rst) |-> {combined_mode, phasing_reserved, second_channel_enable}
      == ($past(pair_phasing_code) == 2'h3 ? 3'h1 : $past(pair_phasing_code) == 2'h2 ? 3'h2
      : 3'h4)) else $error("phasing flags wrong");
  range_shared_a:
    assert property (normal_setpoint_code_a[6] == standby_setpoint_code_a[6]
      && normal_setpoint_code_a[6] == sleep_setpoint_code_a[6]) else $error("range differs");
  range_locked_a:
    assert property (!$past(init_load) && !$past(init_load, 2)
      |-> $stable(normal_setpoint_code_a[6])) else $error("range bit moved");
  write_lands_a:
    assert property (wr_norm_s |-> ##2 normal_setpoint_code_a[5:0] == $past(wr_data_a, 2))
      else $error("normal write lost");
  target_sel_a:
    assert property (!$past(rst) && !reserved_code_a |-> target_mv_a == mv($past(op_state)
      == 2'h1 ? standby_setpoint_code_a : $past(op_state) == 2'h2 ? sleep_setpoint_code_a
      : normal_setpoint_code_a)) else $error("target a wrong");
  comb_follow_a:
    assert property (combined_mode |-> target_mv_b == target_mv_a) else $error("b not a");
  indep_b_a:
    assert property (second_channel_enable && !$past(rst) && $past(op_state) == 2'h0
      |-> target_mv_b == mv(normal_setpoint_code_b)) else $error("target b wrong");
  reserved_hi_a:
    assert property (!$past(rst) && $past(op_state) == 2'h0 |-> reserved_code_a ==
      (normal_setpoint_code_a[6] && normal_setpoint_code_a[5:0] > 6'h32))
      else $error("reserved flag wrong");
endmodule // buck_pair_asserts
bind buck_pair_setpoint buck_pair_asserts chk_i (.*);
`default_nettype wire

// [tb/tb.sv]
// testbench for the buck pair set-point block
// drives the design ports directly, no partner model
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct packed {
    logic [1:0]  ph, st, sel;
    logic [5:0]  da, db;
    logic [11:0] ea, eb;
    logic [2:0]  fl;
  } row_t;
  logic        core_clk = 0, rst = 1, otp_range_a = 0, otp_range_b = 0, init_load = 0;
  logic        wr_en_a = 0, wr_en_b = 0, reserved_code_a, reserved_code_b;
  logic        combined_mode, phasing_reserved, second_channel_enable;
  logic [1:0]  pair_phasing_code = 0, op_state = 0, wr_sel_a = 0, wr_sel_b = 0;
  logic [5:0]  wr_data_a = 0, wr_data_b = 0;
  logic [6:0]  normal_setpoint_code_a, standby_setpoint_code_a, sleep_setpoint_code_a;
  logic [6:0]  normal_setpoint_code_b, standby_setpoint_code_b, sleep_setpoint_code_b;
  logic [11:0] target_mv_a, target_mv_b;
  int          err_total = 0, checks_done = 0;
  row_t        rows [8] = '{
    '{2'h0, 2'h0, 2'h0, 6'h0a, 6'h0a, 12'h28a, 12'h28a, 3'h4},
    '{2'h3, 2'h0, 2'h0, 6'h14, 6'h1e, 12'h384, 12'h47e, 3'h1},
    '{2'h3, 2'h1, 2'h1, 6'h3f, 6'h09, 12'h7b7, 12'h271, 3'h1},
    '{2'h3, 2'h2, 2'h2, 6'h0b, 6'h28, 12'h2a3, 12'h578, 3'h1},
    '{2'h1, 2'h2, 2'h2, 6'h0c, 6'h32, 12'h2bc, 12'h2bc, 3'h4},
    '{2'h3, 2'h3, 2'h0, 6'h10, 6'h3f, 12'h320, 12'h7b7, 3'h1},
    '{2'h3, 2'h3, 2'h3, 6'h21, 6'h21, 12'h320, 12'h7b7, 3'h1},
    '{2'h2, 2'h0, 2'h0, 6'h18, 6'h0f, 12'h3e8, 12'h307, 3'h2}};
  buck_pair_setpoint uut (.*);
  initial forever #25 core_clk = ~core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #5;
  endtask
  task automatic chk(input string nm, input logic [11:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [1:0] sel, input logic [5:0] da, db);
    wr_sel_a = sel; wr_sel_b = sel; wr_data_a = da; wr_data_b = db;
    wr_en_a = 1; wr_en_b = 1; tick(1);
    wr_en_a = 0; wr_en_b = 0; tick(2);
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
  initial begin
    tick(6);
    chk("reset_target", 12'h000, target_mv_a);
    $display("reset hold test done");
    rst = 0; tick(2);
    foreach (rows[i]) begin
      pair_phasing_code = rows[i].ph; op_state = rows[i].st;
      wr(rows[i].sel, rows[i].da, rows[i].db);
      chk("target_a", rows[i].ea, target_mv_a);
      chk("target_b", rows[i].eb, target_mv_b);
      chk("flags", {9'h0, rows[i].fl}, {combined_mode, phasing_reserved, second_channel_enable});
      $display("row %0d done", i);
    end
    chk("stby_b", 12'h009, standby_setpoint_code_b);
    chk("sleep_b", 12'h032, sleep_setpoint_code_b);
    chk("resv_low_b", 12'h000, reserved_code_b);
    pair_phasing_code = 2'h3; op_state = 2'h0; otp_range_a = 1; init_load = 1; tick(1);
    init_load = 0; otp_range_a = 0; tick(2);
    chk("high_a", 12'h7d0, target_mv_a);
    chk("low_b", 12'h307, target_mv_b);
    chk("copy", 12'h003, {standby_setpoint_code_a[6], sleep_setpoint_code_a[6]});
    wr_sel_a = 0; wr_data_a = 6'h32; wr_en_a = 1; tick(1);
    wr_data_a = 6'h33; tick(1);
    chk("top", 12'hce4, target_mv_a);
    wr_en_a = 0; tick(1);
    chk("resv", 12'h001, reserved_code_a);
    $display("range test done");
    rst = 1; tick(1);
    chk("rst_code", 12'h000, normal_setpoint_code_a);
    rst = 0; tick(2);
    chk("rst_range", 12'h190, target_mv_a);
    $display("reset test done");
    otp_range_b = 1; init_load = 1; tick(1);
    init_load = 0; otp_range_b = 0;
    wr(2'h0, 6'h18, 6'h33);
    chk("copy_b", 12'h040, standby_setpoint_code_b);
    chk("off_b", 12'h040, sleep_setpoint_code_b);
    chk("resv_b", 12'h001, reserved_code_b);
    chk("indep_a", 12'h3e8, target_mv_a);
    $display("second channel test done");
    give_verdict;
  end
endmodule // tb
`default_nettype wire
